/* hdl/fcwd_decoder.sv */
/*
  Fieldbus control word decoder: stores the 32-bit command word and turns
  it into registered drive commands for motor control and parameter logic.
  Assumes the writer, the configuration inputs and the fault flag all run
  on mclk; none of them is synchronised here.
*/
// Contract
// - Command bits 0-15 copied unchanged to drive word
// - Bit 0 stops, bit 1 starts, zeros idle
// - Direction is bit 2 xor reference sign
// - Rising bit 4 clears active fault
// - Bus run source: bit 6 high disables running
// - Bits 7-9 pick stop mode, else parameter
// - Bus ramp source: bit 10 picks set 2
// - Bit 14 high blocks switching to local
// - Bus torque source: bit 15 picks set 2
// - Bit 16 high takes local command control
// - Bit 17 high takes local setpoint control
// - Bits 22-25 are free user bits
// - Bits 11-13 zero output, hold, zero input
`timescale 1ns/1ps
module fcwd_decoder
  import fcwd_pkg::*;
(
  input  wire logic                  mclk,                 // 25 MHz clock
  input  wire logic                  rst_n,                // Sync reset
  input  wire logic                  cmd_write,            // Word strobe
  input  wire logic [WORD_W-1:0]     fieldbus_command_word, // Word data
  input  wire logic                  reference_negative,   // Ref sign
  input  wire logic                  fault_active,         // Fault present
  input  wire logic                  run_from_bus,         // Run src bus
  input  wire logic                  run_enable_other,     // Other run src
  input  wire logic                  ramp_from_bus,        // Ramp src bus
  input  wire logic                  ramp_set_param,       // Param ramp set
  input  wire logic                  torque_from_bus,      // Torq src bus
  input  wire logic                  torque_set_param,     // Param torq set
  input  wire logic                  location_from_bus,    // Loc src bus
  input  wire logic                  location_param,       // Param location
  input  wire fcwd_pkg::fcwd_stop_mode_t param_stop_mode,  // Config stop
  output logic [LOW_W-1:0]           drive_control_word,   // Bits 0-15
  output logic                       stop_request,         // Stop level
  output logic                       start_request,        // Start level
  output logic                       motor_reverse,        // 1 = reverse
  output logic                       fault_clear,          // 1-cycle pulse
  output logic                       run_enable,           // Run granted
  output logic                       stop_normal_slope,    // Bit 7 copy
  output logic                       stop_emergency_slope, // Bit 8 copy
  output logic                       stop_freewheel,       // Bit 9 copy
  output fcwd_pkg::fcwd_stop_mode_t  stop_mode,            // Effective mode
  output logic                       accel_set_select,     // 1 = set 2
  output logic                       ramp_out_zero,        // Ramp out to 0
  output logic                       ramp_hold,            // Freeze ramp
  output logic                       ramp_in_zero,         // Ramp in to 0
  output logic                       local_lock,           // Block local
  output logic                       torque_set_select,    // 1 = set 2
  output logic                       take_local_command,   // Steal control
  output logic                       take_local_setpoint,  // Steal ref
  output logic [USER_W-1:0]          user_bits,            // Free bits
  output logic                       external_location_select // 1 = loc 2
);

  logic [WORD_W-1:0]  word;
  logic               fault_bit_prev;
  fcwd_stop_mode_t    next_stop_mode;

  // Bits 18-21 and 26-31 are stored but no logic below reads them; bit 3 only goes to drive_control_word
  fcwd_word_store
  #(
    .WIDTH   (WORD_W),
    .INIT    (WORD_RESET)
  )
  fcwd_word_store_i
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (cmd_write),
    .wr_data (fieldbus_command_word),
    .rd_data (word)
  );

  // Coast wins over emergency, emergency over normal: the harder stop is
  // the safer reading when the master sets more than one request bit.
  always_comb
  begin
    if (word[B_STOP_FREE])
      next_stop_mode = FCWD_STOP_FREE;
    else if (word[B_STOP_EMER])
      next_stop_mode = FCWD_STOP_EMER;
    else if (word[B_STOP_NORM])
      next_stop_mode = FCWD_STOP_NORM;
    else
      next_stop_mode = param_stop_mode;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      drive_control_word <= '0;
    else
      drive_control_word <= word[LOW_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stop_request  <= 1'b0;
      start_request <= 1'b0;
      stop_mode     <= FCWD_STOP_PARAM;
    end
    else
    begin
      stop_request  <= word[B_STOP];
      start_request <= word[B_START];
      stop_mode     <= next_stop_mode;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stop_normal_slope    <= 1'b0;
      stop_emergency_slope <= 1'b0;
      stop_freewheel       <= 1'b0;
    end
    else
    begin
      stop_normal_slope    <= word[B_STOP_NORM];
      stop_emergency_slope <= word[B_STOP_EMER];
      stop_freewheel       <= word[B_STOP_FREE];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      motor_reverse <= 1'b0;
    else
      motor_reverse <= word[B_REVERSE] ^ reference_negative;
  end

  // Edge is taken on the stored word, so rewriting the same 1 never
  // clears a second fault; the master must write 0 first.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fault_bit_prev <= 1'b0;
      fault_clear    <= 1'b0;
    end
    else
    begin
      fault_bit_prev <= word[B_FAULT_CLR];
      fault_clear    <= word[B_FAULT_CLR] & ~fault_bit_prev
                        & fault_active;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      run_enable <= 1'b0;
    else if (run_from_bus)
      run_enable <= ~word[B_RUN_DIS];
    else
      run_enable <= run_enable_other;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      accel_set_select         <= 1'b0;
      torque_set_select        <= 1'b0;
      external_location_select <= 1'b0;
    end
    else
    begin
      accel_set_select  <= ramp_from_bus ? word[B_ACCEL_SET]
                                         : ramp_set_param;
      torque_set_select <= torque_from_bus ? word[B_TORQ_SET]
                                           : torque_set_param;
      external_location_select <= location_from_bus ? word[B_EXT_LOC]
                                                    : location_param;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ramp_out_zero <= 1'b0;
      ramp_hold     <= 1'b0;
      ramp_in_zero  <= 1'b0;
    end
    else
    begin
      ramp_out_zero <= word[B_RAMP_OUT0];
      ramp_hold     <= word[B_RAMP_HOLD];
      ramp_in_zero  <= word[B_RAMP_IN0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      local_lock          <= 1'b0;
      take_local_command  <= 1'b0;
      take_local_setpoint <= 1'b0;
    end
    else
    begin
      local_lock          <= word[B_LOC_LOCK];
      take_local_command  <= word[B_TAKE_CMD];
      take_local_setpoint <= word[B_TAKE_SP];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      user_bits <= '0;
    else
      user_bits <= word[B_USER_LO +: USER_W];
  end

endmodule

/* hdl/fcwd_pkg.sv */
/*
  Package for the fieldbus control word decoder: bit positions of the
  command word, stop mode encoding, widths and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcwd_pkg;

  localparam int unsigned WORD_W   = 32;
  localparam int unsigned LOW_W    = 16;
  localparam int unsigned USER_W   = 4;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Bit positions inside the fieldbus command word
  localparam int unsigned B_STOP      = 0;
  localparam int unsigned B_START     = 1;
  localparam int unsigned B_REVERSE   = 2;
  localparam int unsigned B_FAULT_CLR = 4;
  localparam int unsigned B_EXT_LOC   = 5;
  localparam int unsigned B_RUN_DIS   = 6;
  localparam int unsigned B_STOP_NORM = 7;
  localparam int unsigned B_STOP_EMER = 8;
  localparam int unsigned B_STOP_FREE = 9;
  localparam int unsigned B_ACCEL_SET = 10;
  localparam int unsigned B_RAMP_OUT0 = 11;
  localparam int unsigned B_RAMP_HOLD = 12;
  localparam int unsigned B_RAMP_IN0  = 13;
  localparam int unsigned B_LOC_LOCK  = 14;
  localparam int unsigned B_TORQ_SET  = 15;
  localparam int unsigned B_TAKE_CMD  = 16;
  localparam int unsigned B_TAKE_SP   = 17;
  localparam int unsigned B_USER_LO   = 22;

  typedef enum logic [1:0] {
    FCWD_STOP_PARAM = 2'b00,
    FCWD_STOP_NORM  = 2'b01,
    FCWD_STOP_EMER  = 2'b10,
    FCWD_STOP_FREE  = 2'b11
  } fcwd_stop_mode_t;

endpackage

/* hdl/fcwd_word_store.sv */
/*
  Holding register for the last command word written by the master.
  Read data come straight out of the register. Same clock as the writer.
*/
`timescale 1ns/1ps
module fcwd_word_store
#(
  parameter int unsigned         WIDTH = 32,
  parameter logic [WIDTH-1:0]    INIT  = '0
)
(
  input  wire logic              mclk,     // System clock
  input  wire logic              rst_n,    // Synchronous reset
  input  wire logic              wr_en,    // Write strobe
  input  wire logic [WIDTH-1:0]  wr_data,  // Word to store
  output logic      [WIDTH-1:0]  rd_data   // Stored word
);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rd_data <= INIT;
    else if (wr_en)
      rd_data <= wr_data;
  end

endmodule

/* bench/fcwd_bus_master.sv */
/* Fieldbus master model: turns a bench send request into a one-cycle
   command word write. Assumes the decoder's mclk. */
`timescale 1ns/1ps
module fcwd_bus_master
(
  input  wire logic        mclk,      // Clock
  input  wire logic        send,      // Bench asks for a write
  input  wire logic [31:0] word,      // Word to send
  output logic             cmd_write, // Write strobe
  output logic      [31:0] data       // Word lines
);
  initial cmd_write = 1'b0;
  initial data = 32'h0000_0000;
  // Idle lines toggle so a stale word never looks like a fresh one
  always @(posedge mclk)
  begin
    cmd_write <= send;
    data      <= send ? word : ~data;
  end
endmodule

/* bench/fcwd_decoder_properties.sv */
/* Port assertions for the command word decoder.
   Assumes one clock mclk and synchronous active-low rst_n. */
`timescale 1ns/1ps
module fcwd_decoder_checker
  import fcwd_pkg::*;
(
  input wire logic              mclk,                  // Clock
  input wire logic              rst_n,                 // Reset
  input wire logic              cmd_write,             // Strobe
  input wire logic [WORD_W-1:0] fieldbus_command_word, // Word
  input wire logic              reference_negative,    // Sign
  input wire logic              fault_active,          // Fault
  input wire logic              run_from_bus,          // Run src
  input wire logic              run_enable_other,      // Other run
  input wire logic              ramp_from_bus,         // Ramp src
  input wire logic              ramp_set_param,        // Ramp param
  input wire fcwd_stop_mode_t   param_stop_mode,       // Stop param
  input wire logic [LOW_W-1:0]  drive_control_word,    // Low word
  input wire logic              stop_request,          // Stop
  input wire logic              start_request,         // Start
  input wire logic              motor_reverse,         // Direction
  input wire logic              fault_clear,           // Pulse
  input wire logic              run_enable,            // Run
  input wire fcwd_stop_mode_t   stop_mode,             // Mode
  input wire logic              accel_set_select,      // Ramp set
  input wire logic              take_local_command,    // Steal ctl
  input wire logic              take_local_setpoint,   // Steal ref
  input wire logic [USER_W-1:0] user_bits              // User
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  copy_low_a: assert property (
    cmd_write |-> ##2
    drive_control_word == $past(fieldbus_command_word[15:0], 2))
    else $error("low word not copied");
  upper_bits_a: assert property (
    cmd_write |-> ##2 {user_bits, take_local_setpoint, take_local_command}
    == {$past(fieldbus_command_word[25:22], 2),
    $past(fieldbus_command_word[17:16], 2)})
    else $error("upper bits wrong");
  start_stop_a: assert property (
    cmd_write |-> ##2 {start_request, stop_request}
    == $past(fieldbus_command_word[1:0], 2))
    else $error("start or stop wrong");
  motor_direction_a: assert property (
    $past(rst_n) |->
    motor_reverse == (drive_control_word[2] ^ $past(reference_negative)))
    else $error("direction wrong");
  fault_pulse_a: assert property (
    fault_clear |-> drive_control_word[4] && $past(fault_active)
    ##1 !fault_clear)
    else $error("fault clear pulse wrong");
  fault_edge_a: assert property (
    $rose(drive_control_word[4]) && $past(fault_active) |-> fault_clear)
    else $error("fault clear missed");
  run_enable_a: assert property (
    $past(rst_n) |-> run_enable == ($past(run_from_bus) ?
    !drive_control_word[6] : $past(run_enable_other)))
    else $error("run enable wrong");
  stop_mode_a: assert property (
    $past(rst_n) |-> stop_mode == (drive_control_word[9] ? FCWD_STOP_FREE :
    drive_control_word[8] ? FCWD_STOP_EMER : drive_control_word[7] ?
    FCWD_STOP_NORM : $past(param_stop_mode)))
    else $error("stop mode wrong");
  accel_set_a: assert property (
    $past(rst_n) |-> accel_set_select == ($past(ramp_from_bus) ?
    drive_control_word[10] : $past(ramp_set_param)))
    else $error("ramp set wrong");
endmodule
bind fcwd_decoder fcwd_decoder_checker fcwd_decoder_checker_i (.mclk,
  .rst_n, .cmd_write, .fieldbus_command_word, .reference_negative,
  .fault_active, .run_from_bus, .run_enable_other, .ramp_from_bus,
  .ramp_set_param, .param_stop_mode, .drive_control_word, .stop_request,
  .start_request, .motor_reverse, .fault_clear, .run_enable, .stop_mode,
  .accel_set_select, .take_local_command, .take_local_setpoint, .user_bits);

/* bench/fcwd_decoder_tb.sv */
/* Bench for the command word decoder: words go through the master model
   and every decoded output is compared. Assumes nothing else drives. */
`timescale 1ns/1ps
module fcwd_decoder_tb;
  import fcwd_pkg::*;
  logic            mclk, cmd_write, fclr, run, acc, tq, loc, rev, stp, sta;
  logic            n_s, e_s, f_s, ro, rh, ri, lk, tc, ts;
  logic            rst_n = 1'b0, send = 1'b0, fault_active = 1'b0;
  logic [31:0]     data, word = 32'h0000_0000;
  logic [8:0]      cfg = 9'h000;
  fcwd_stop_mode_t pm = FCWD_STOP_PARAM, mode;
  logic [15:0]     dcw;
  logic [3:0]      user;
  logic [37:0]     obs;
  int              errors = 0, check_count = 0, pulses;
  logic [31:0] words [8] = '{32'h0000_0000, 32'h0000_0081, 32'h0000_0004,
    32'h0000_0005, 32'h0000_0101, 32'h0000_0381, 32'hFFFF_FFFF,
    32'hFC3C_0008};
  logic [31:0] fw [4] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_0000,
    32'h0000_0010};
  assign obs = {dcw, stp, sta, rev, run, mode, acc, tq, loc, ts, tc, user,
    f_s, e_s, n_s, lk, ri, rh, ro};
  fcwd_bus_master fcwd_bus_master_i (.mclk(mclk), .send(send), .word(word),
    .cmd_write(cmd_write), .data(data));
  fcwd_decoder fcwd_decoder_i (.mclk(mclk), .rst_n(rst_n),
    .cmd_write(cmd_write), .fieldbus_command_word(data),
    .reference_negative(cfg[8]), .fault_active(fault_active),
    .run_from_bus(cfg[7]), .run_enable_other(cfg[6]),
    .ramp_from_bus(cfg[5]), .ramp_set_param(cfg[4]),
    .torque_from_bus(cfg[3]), .torque_set_param(cfg[2]),
    .location_from_bus(cfg[1]), .location_param(cfg[0]),
    .param_stop_mode(pm), .drive_control_word(dcw), .stop_request(stp),
    .start_request(sta), .motor_reverse(rev), .fault_clear(fclr),
    .run_enable(run), .stop_normal_slope(n_s), .stop_emergency_slope(e_s),
    .stop_freewheel(f_s), .stop_mode(mode), .accel_set_select(acc),
    .ramp_out_zero(ro), .ramp_hold(rh), .ramp_in_zero(ri), .local_lock(lk),
    .torque_set_select(tq), .take_local_command(tc),
    .take_local_setpoint(ts), .user_bits(user),
    .external_location_select(loc));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Reserved bits never reach the expectation, so any leak shows up
  function automatic logic [37:0] expect_of(logic [31:0] w, logic [1:0] p,
    logic [8:0] c);
    logic [1:0] m;
    m = w[9] ? 2'h3 : w[8] ? 2'h2 : w[7] ? 2'h1 : p;
    return {w[15:0], w[0], w[1], w[2] ^ c[8], c[7] ? ~w[6] : c[6], m,
      c[5] ? w[10] : c[4], c[3] ? w[15] : c[2], c[1] ? w[5] : c[0],
      w[17:16], w[25:22], w[9:7], w[14:11]};
  endfunction
  task automatic chk(logic [37:0] seen, logic [37:0] want);
    check_count++;
    if (seen !== want)
    begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Entered at a rising edge; outputs settle two edges after the strobe
  task automatic put(logic [31:0] w, logic [37:0] want, int npulse);
    send <= 1'b1;
    word <= w;
    @(posedge mclk);
    send <= 1'b0;
    pulses = 0;
    repeat (4)
    begin
      @(posedge mclk);
      #1 pulses += int'(fclr);
    end
    chk(obs, want);
    chk(38'(pulses), 38'(npulse));
    @(posedge mclk);
  endtask
  initial
  begin
    #1000000 errors++;
    tally_and_finish;
  end
  initial
  begin
    logic [8:0] c;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 chk(obs, 38'h0);
    @(posedge mclk);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      c = i[0] ? 9'h155 : 9'h0AA;
      cfg <= c;
      pm <= fcwd_stop_mode_t'(i[1:0]);
      put(words[i], expect_of(words[i], i[1:0], c), 0);
    end
    $display("test decode done");
    for (int k = 0; k < 4; k++)
    begin
      fault_active <= (k < 2);
      put(fw[k], expect_of(fw[k], 2'h3, 9'h155), int'(k == 0));
    end
    $display("test fault clear done");
    send <= 1'b1;
    word <= 32'h0000_8421;
    @(posedge mclk);
    put(32'h0340_4A40, expect_of(32'h0340_4A40, 2'h3, 9'h155), 0);
    $display("test back to back done");
    tally_and_finish;
  end
endmodule
